// *** pkg/beam_map_defines.svh ***
// Purpose: offsets, field positions, reset values and scaling constants
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   included by its bare name
`ifndef BEAM_MAP_DEFINES_SVH
`define BEAM_MAP_DEFINES_SVH
`define CTRL_OFF      12'h000
`define BEAM_OFF      12'h004
`define FILT_OFF      12'h008
`define COMMIT_OFF    12'h00C
`define STATUS_OFF    12'h010
`define ACTIVE_OFF    12'h014
// packed configuration word
`define RANGE_LSB     0
`define FUNC_LSB      4
`define START_LSB     8
`define END_LSB       16
`define DEPTH_LSB     24
`define CFG_RESET     32'h0120_0100
`define FULL_STEPS    21'h001000
`define CODE_MAX      12'hFFF
// 4 mA live zero of a 20 mA full scale converter
`define LIVE_ZERO     12'h333
`define LIVE_SPAN     24'h000CCC
`endif

// *** pkg/beam_map_pkg.sv ***
// Purpose: types shared by the beam to analog mapper
// Assumes: nothing
// Notes:   range and function enums are cast from 3-bit register fields
package beam_map_pkg;
  typedef enum logic [2:0] {
    range_off, range_0_5v, range_0_10v, range_0_11v,
    range_4_20ma, range_0_20ma, range_0_24ma
  } range_t;
  typedef enum logic [2:0] {
    func_off, first_blocked_beam_func, first_clear_beam_func,
    last_blocked_beam_func, last_clear_beam_func,
    total_blocked_beams_func, total_clear_beams_func
  } func_t;
  typedef enum logic {boot_st, run_st} phase_t;
endpackage

// *** rtl/beam_map.sv ***
// Purpose: maps filtered beam states to a 12-bit analog converter code
// Assumes: apb slave, beams_in bit set means beam interrupted
// Notes:   one answer per transfer, pready a cycle after access starts
//
// Functional notes
// (R01) range setting: off, 0-5V, 0-10V, 0-11V, 4-20mA, 0-20mA, 0-24mA.
// (R02) function setting: off or one of six beam evaluations.
// (R03) first interrupted beam index drives output inside measurement range.
// (R04) start beam sets curve low end, end beam sets high end.
// (R05) code is 4096 steps divided by number of beams in range.
// (R06) start above end inverts the curve.
// (R07) start and end accepted anywhere from 1 to n.
// (R08) all free gives low end, all interrupted full scale, half mid.
// (R09) settings kept in non-volatile store and restored at power-up.
// (R10) latest write wins, panel or link.
// (R11) link settings apply once the whole set is transferred.
// (R12) two connector pins may serve as analog outputs.
// (R13) evaluate only after beams stay stable for filter depth cycles.
// (R14) filter depth must be 1 to 255, else refused.
// (R15) other functions: first/last clear, last blocked, totals.
// (R16) code = offset times 4096 over count, clamped, zero when off.
//
// The placing of the registers and register access over APB are this design's own decisions.
`include "beam_map_defines.svh"
module beam_map #(
  parameter int BEAMS = 32
) (
  input  wire logic              ref_clk_in,
  input  wire logic              reset_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [11:0]       paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic      [31:0]       prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  input  wire logic [BEAMS-1:0]  beams_in,
  input  wire logic              meas_strobe_in,
  input  wire logic              panel_we_in,
  input  wire logic [31:0]       panel_cfg_in,
  input  wire logic [31:0]       nv_data_in,
  output logic                   nv_wr_out,
  output logic      [31:0]       nv_data_out,
  output logic      [11:0]       dac_code_out,
  output logic                   volt_pin_en_out,
  output logic                   curr_pin_en_out
);
  if (BEAMS < 1 || BEAMS > 255) begin
    $error("BEAMS must be 1 to 255");
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic cfg_ok(input logic [31:0] c);
    logic [7:0] s;
    logic [7:0] e;
    s = c[`START_LSB +: 8];
    e = c[`END_LSB +: 8];
    cfg_ok = s != 8'h00 && e != 8'h00 && 32'(s) <= BEAMS
      && 32'(e) <= BEAMS && c[`DEPTH_LSB +: 8] != 8'h00
      && c[`RANGE_LSB +: 3] != 3'h7 && c[`FUNC_LSB +: 3] != 3'h7;
  endfunction

  // position of the chosen beam counted from 1 at the low end, or the beam count for the totals, 0 when none found
  function automatic logic [8:0] beam_offset(
    input logic [BEAMS-1:0] b, input logic [7:0] lo,
    input logic [7:0] hi, input beam_map_pkg::func_t f);
    logic [8:0] fb;
    logic [8:0] fc;
    logic [8:0] lb;
    logic [8:0] lc;
    logic [8:0] tb;
    logic [8:0] tc;
    logic [8:0] off;
    fb = 9'h000;
    fc = 9'h000;
    lb = 9'h000;
    lc = 9'h000;
    tb = 9'h000;
    tc = 9'h000;
    for (int i = 0; i < BEAMS; i++) begin
      off = 9'(i + 2) - {1'b0, lo};
      if (32'(i + 1) >= 32'(lo) && 32'(i + 1) <= 32'(hi)) begin
        if (b[i]) begin
          if (fb == 9'h000)
            fb = off;
          lb = off;
          tb = tb + 9'h001;
        end else begin
          if (fc == 9'h000)
            fc = off;
          lc = off;
          tc = tc + 9'h001;
        end
      end
    end
    case (f)
      beam_map_pkg::first_blocked_beam_func: beam_offset = fb; // [R03]
      beam_map_pkg::first_clear_beam_func:   beam_offset = fc; // [R15]
      beam_map_pkg::last_blocked_beam_func:  beam_offset = lb; // [R15]
      beam_map_pkg::last_clear_beam_func:    beam_offset = lc; // [R15]
      beam_map_pkg::total_blocked_beams_func: beam_offset = tb; // [R15]
      beam_map_pkg::total_clear_beams_func:  beam_offset = tc; // [R15]
      default:                               beam_offset = 9'h000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // configuration and apb slave
  beam_map_pkg::phase_t phase_reg, phase_next;
  logic [31:0] shadow_reg, shadow_next;
  logic [31:0] active_reg, active_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic        nv_wr_reg, nv_wr_next;
  logic [11:0] code_reg, code_next;
  logic        stable_seen_reg, stable_seen_next;
  logic        access;
  logic        wr_hit;
  logic [31:0] cand;

  assign access = psel_in && penable_in && !pready_reg;
  assign wr_hit = access && pwrite_in;

  always_comb begin
    phase_next = beam_map_pkg::run_st;
    shadow_next = shadow_reg;
    active_next = active_reg;
    prdata_next = 32'h0000_0000;
    pready_next = access;
    pslverr_next = 1'b0;
    nv_wr_next = 1'b0;
    cand = shadow_reg;
    case (paddr_in)
      `CTRL_OFF: begin
        cand[`RANGE_LSB +: 3] = pwdata_in[2:0]; // [R01]
        cand[`FUNC_LSB +: 3] = pwdata_in[6:4];  // [R02]
      end
      `BEAM_OFF: begin
        cand[`START_LSB +: 8] = pwdata_in[7:0];  // [R04]
        cand[`END_LSB +: 8] = pwdata_in[15:8];
      end
      `FILT_OFF: cand[`DEPTH_LSB +: 8] = pwdata_in[7:0];
      default: cand = shadow_reg;
    endcase
    if (access) begin
      case (paddr_in)
        `CTRL_OFF: prdata_next = {25'h0, shadow_reg[6:0]};
        `BEAM_OFF: prdata_next = {16'h0, shadow_reg[23:8]};
        `FILT_OFF: prdata_next = {24'h0, shadow_reg[31:24]};
        `COMMIT_OFF: prdata_next = 32'h0000_0000;
        `STATUS_OFF: prdata_next = {15'h0, stable_seen_reg,
                                    4'h0, code_reg};
        `ACTIVE_OFF: prdata_next = active_reg;
        default: pslverr_next = 1'b1;
      endcase
      if (wr_hit) begin
        case (paddr_in)
          `CTRL_OFF, `BEAM_OFF, `FILT_OFF: begin
            // bad beam numbers or depth are refused, old value kept
            if (cfg_ok(cand))             // [R07] [R14]
              shadow_next = cand;
            else
              pslverr_next = 1'b1;
          end
          `COMMIT_OFF: begin
            // whole set lands at once, never a half written curve
            active_next = shadow_reg;     // [R11] [R10]
            nv_wr_next = 1'b1;            // [R09]
          end
          `STATUS_OFF, `ACTIVE_OFF: pslverr_next = 1'b1;
          default: pslverr_next = 1'b1;
        endcase
      end
    end
    if (panel_we_in && cfg_ok(panel_cfg_in)) begin
      // panel write is latest, so it overrides a pending link set
      active_next = panel_cfg_in;         // [R10]
      shadow_next = panel_cfg_in;
      nv_wr_next = 1'b1;                  // [R09]
    end
    if (phase_reg == beam_map_pkg::boot_st) begin
      // restore from store one edge after reset release
      active_next = cfg_ok(nv_data_in) ? nv_data_in : `CFG_RESET; // [R09]
      shadow_next = active_next;
      nv_wr_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      phase_reg <= beam_map_pkg::boot_st;
      shadow_reg <= `CFG_RESET;
      active_reg <= `CFG_RESET;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      nv_wr_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      shadow_reg <= shadow_next;
      active_reg <= active_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      nv_wr_reg <= nv_wr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stability filter
  logic [BEAMS-1:0] last_reg, last_next;
  logic [BEAMS-1:0] stable_reg, stable_next;
  logic [7:0]       same_reg, same_next;
  logic [7:0]       depth;

  assign depth = active_reg[`DEPTH_LSB +: 8];

  always_comb begin
    last_next = last_reg;
    stable_next = stable_reg;
    same_next = same_reg;
    stable_seen_next = stable_seen_reg;
    if (meas_strobe_in) begin
      last_next = beams_in;
      if (beams_in == last_reg && same_reg != 8'hFF)
        same_next = same_reg + 8'h01;
      else if (beams_in != last_reg)
        same_next = 8'h01;
      // one noisy cycle restarts the count
      if (same_next >= depth) begin       // [R13]
        stable_next = beams_in;
        stable_seen_next = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      last_reg <= '0;
      stable_reg <= '0;
      same_reg <= 8'h00;
      stable_seen_reg <= 1'b0;
    end else begin
      last_reg <= last_next;
      stable_reg <= stable_next;
      same_reg <= same_next;
      stable_seen_reg <= stable_seen_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // curve and converter code
  beam_map_pkg::range_t rng;
  beam_map_pkg::func_t  fn;
  logic [7:0]  st_beam;
  logic [7:0]  en_beam;
  logic [7:0]  lo;
  logic [7:0]  hi;
  logic [8:0]  cnt;
  logic [8:0]  offset;
  logic [20:0] quot;
  logic [11:0] dac_reg, dac_next;
  logic        volt_reg, volt_next;
  logic        curr_reg, curr_next;
  logic [23:0] live;

  assign rng = beam_map_pkg::range_t'(active_reg[`RANGE_LSB +: 3]);
  assign fn = beam_map_pkg::func_t'(active_reg[`FUNC_LSB +: 3]);
  assign st_beam = active_reg[`START_LSB +: 8];
  assign en_beam = active_reg[`END_LSB +: 8];

  always_comb begin
    // start above end swaps the ends and flips the code
    lo = (st_beam > en_beam) ? en_beam : st_beam;    // [R04] [R06]
    hi = (st_beam > en_beam) ? st_beam : en_beam;
    cnt = {1'b0, hi} - {1'b0, lo} + 9'h001;
    offset = beam_offset(stable_reg, lo, hi, fn);
    // few beams give a coarse staircase, by design
    quot = {offset, 12'h000} / 21'(cnt);              // [R05] [R16]
    code_next = (quot > 21'(`CODE_MAX)) ? `CODE_MAX : quot[11:0]; // [R08]
    if (st_beam > en_beam)
      code_next = `CODE_MAX - code_next;              // [R06]
    if (fn == beam_map_pkg::func_off)
      code_next = 12'h000;                            // [R16]
    live = 24'(code_reg) * `LIVE_SPAN;
    // converter full scale is the range top; 4-20 mA adds live zero
    case (rng)
      beam_map_pkg::range_off: dac_next = 12'h000;      // [R01]
      beam_map_pkg::range_4_20ma:
        dac_next = `LIVE_ZERO + live[23:12];          // [R01] [R08]
      default: dac_next = code_reg;
    endcase
    volt_next = rng inside {beam_map_pkg::range_0_5v,
      beam_map_pkg::range_0_10v, beam_map_pkg::range_0_11v}; // [R12]
    curr_next = rng inside {beam_map_pkg::range_4_20ma,
      beam_map_pkg::range_0_20ma, beam_map_pkg::range_0_24ma}; // [R12]
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      code_reg <= 12'h000;
      dac_reg <= 12'h000;
      volt_reg <= 1'b0;
      curr_reg <= 1'b0;
    end else begin
      code_reg <= code_next;
      dac_reg <= dac_next;
      volt_reg <= volt_next;
      curr_reg <= curr_next;
    end
  end

  assign prdata_out = prdata_reg;
  assign pready_out = pready_reg;
  assign pslverr_out = pslverr_reg;
  assign nv_wr_out = nv_wr_reg;
  assign nv_data_out = active_reg;
  assign dac_code_out = dac_reg;
  assign volt_pin_en_out = volt_reg;
  assign curr_pin_en_out = curr_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  commit_apply_a: assert property ( // [R11]
    wr_hit && paddr_in == `COMMIT_OFF && !panel_we_in
    && phase_reg == beam_map_pkg::run_st
    |=> active_reg == $past(shadow_reg) && nv_wr_reg)
    else $error("commit did not apply shadow set");
  panel_wins_a: assert property ( // [R10]
    panel_we_in && cfg_ok(panel_cfg_in)
    && phase_reg == beam_map_pkg::run_st
    |=> active_reg == $past(panel_cfg_in) && shadow_reg == active_reg)
    else $error("panel write lost");
  nv_store_a: assert property ( // [R09]
    nv_wr_out |-> $past(panel_we_in)
    || $past(wr_hit && paddr_in == `COMMIT_OFF))
    else $error("store write without new settings");
  depth_refuse_a: assert property ( // [R14]
    wr_hit && paddr_in == `FILT_OFF && pwdata_in[7:0] == 8'h00 && !panel_we_in
    |=> pslverr_out && pready_out && $stable(shadow_reg))
    else $error("zero filter depth accepted");
  beam_limit_a: assert property ( // [R07]
    shadow_reg[`START_LSB +: 8] != 8'h00
    && 32'(shadow_reg[`END_LSB +: 8]) <= BEAMS)
    else $error("beam number out of range stored");
  filter_hold_a: assert property ( // [R13]
    $changed(stable_reg) |-> $past(same_next) >= $past(depth))
    else $error("beams taken before filter depth");
  func_off_a: assert property ( // [R16]
    fn == beam_map_pkg::func_off && $stable(fn) [*2]
    |-> code_reg == 12'h000)
    else $error("code not zero with function off");
  range_off_a: assert property ( // [R01]
    rng == beam_map_pkg::range_off [*3]
    |-> dac_code_out == 12'h000 && !volt_pin_en_out
        && !curr_pin_en_out)
    else $error("output active with range off");
  invert_ends_a: assert property ( // [R06]
    st_beam > en_beam && fn != beam_map_pkg::func_off
    && offset == 9'h000 && $stable(active_reg) && $stable(stable_reg)
    |=> code_reg == `CODE_MAX)
    else $error("inverted curve low end wrong");
  apb_answer_a: assert property (
    psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out)
    else $error("apb answer not one cycle late");
endmodule

// *** tb/plc_analog_in.sv ***
// Purpose: controller analog input reading the two connector pins
// Assumes: a pin that is not driven reads zero through the input load
// Notes:   one sample per clock, no filtering
module plc_analog_in (
  input  wire logic        ref_clk_in,
  input  wire logic [11:0] dac_code_in,
  input  wire logic        volt_pin_en_in,
  input  wire logic        curr_pin_en_in,
  output logic      [11:0] volt_val_out,
  output logic      [11:0] curr_val_out
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  // undriven pin is pulled to zero by the input burden
  always_ff @(posedge ref_clk_in) begin
    volt_val_out <= volt_pin_en_in ? dac_code_in : 12'h000;
    curr_val_out <= curr_pin_en_in ? dac_code_in : 12'h000;
  end
endmodule

// *** tb/testbench.sv ***
// Purpose: self-checking bench for the beam to analog mapper
// Assumes: bit i of the beam word is beam i+1, 32 beams fitted
// Notes:   expected codes worked out by hand from the curve scaling
`include "beam_map_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0;
  logic        pwr = 1'b0, strobe = 1'b0, pwe = 1'b0;
  logic        pready, pslverr, nvw, ven, cen, e;
  logic [11:0] paddr = 12'h000;
  logic [11:0] dac, vv, cv;
  logic [31:0] pwdata = 32'h0, beams = 32'h0, pcfg = 32'h0, nvd = 32'h0;
  logic [31:0] prdata, nvq, q, k;
  logic [31:0] nwr = 32'h0;
  logic [11:0] exp_tab [7];
  int          n_mismatch = 0;
  int          samples_checked = 0;
  ////////////////////////////////////////
  beam_map #(.BEAMS(32)) dut_u (
    .ref_clk_in(clk), .reset_in(rst), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .beams_in(beams), .meas_strobe_in(strobe),
    .panel_we_in(pwe), .panel_cfg_in(pcfg), .nv_data_in(nvd),
    .nv_wr_out(nvw), .nv_data_out(nvq), .dac_code_out(dac),
    .volt_pin_en_out(ven), .curr_pin_en_out(cen));
  plc_analog_in plc_u (
    .ref_clk_in(clk), .dac_code_in(dac), .volt_pin_en_in(ven),
    .curr_pin_en_in(cen), .volt_val_out(vv), .curr_val_out(cv));
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (nvw === 1'b1) nwr <= nwr + 32'h1;
  end
  initial begin
    #40000;
    n_mismatch++;
    end_sim();
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cd(input logic [31:0] x);
    chk({20'h0, dac}, x);
  endtask
  // leading idle edge: psel is never assigned twice in one step
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    if (pready !== 1'b1) n_mismatch++;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic x);
    xfer(1'b1, a, d);
    chk({31'h0, e}, {31'h0, x});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic setcfg(input logic [7:0] c, input logic [7:0] s,
                        input logic [7:0] en, input logic [7:0] dp);
    wr(`CTRL_OFF, {24'h0, c}, 1'b0);
    wr(`BEAM_OFF, {16'h0, en, s}, 1'b0);
    wr(`FILT_OFF, {24'h0, dp}, 1'b0);
    wr(`COMMIT_OFF, 32'h0, 1'b0);
  endtask
  // extra settle edges cover the three-edge output path and the plc
  task automatic meas(input logic [31:0] p, input int n);
    repeat (n) begin
      @(posedge clk);
      beams <= p;
      strobe <= 1'b1;
      @(posedge clk);
      strobe <= 1'b0;
    end
    repeat (6) @(posedge clk);
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    exp_tab = '{12'h000, 12'h280, 12'h080, 12'h600,
                12'hFFF, 12'h400, 12'hC00};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(`ACTIVE_OFF, `CFG_RESET);
    wr(`CTRL_OFF, 32'h0000_0014, 1'b0);
    wr(`BEAM_OFF, 32'h0000_2001, 1'b0);
    rd(`ACTIVE_OFF, `CFG_RESET);
    k = nwr;
    wr(`COMMIT_OFF, 32'h0, 1'b0);
    rd(`ACTIVE_OFF, 32'h0120_0114);
    chk(nvq, 32'h0120_0114);
    chk(nwr, k + 32'h1);
    meas(32'h0000_8000, 1);
    cd(32'd2457);
    chk({20'h0, cv}, 32'd2457);
    chk({20'h0, vv}, 32'h0);
    meas(32'h0, 1);
    cd(32'd819);
    wr(`CTRL_OFF, 32'h0000_0034, 1'b0);
    wr(`COMMIT_OFF, 32'h0, 1'b0);
    meas(32'hFFFF_FFFF, 1);
    cd(32'd4094);
    // eight beams in range: steps of 512
    setcfg(8'h12, 8'd9, 8'd16, 8'd1);
    meas(32'h0000_0400, 1);
    cd(32'd1536);
    setcfg(8'h12, 8'd16, 8'd9, 8'd1);
    meas(32'h0000_0400, 1);
    cd(32'd2559);
    meas(32'h0, 1);
    cd(32'd4095);
    setcfg(8'h12, 8'd1, 8'd32, 8'd1);
    for (int f = 0; f < 7; f++) begin
      wr(`CTRL_OFF, {25'h0, f[2:0], 4'h2}, 1'b0);
      wr(`COMMIT_OFF, 32'h0, 1'b0);
      meas(32'h0000_0FF0, 1);
      cd({20'h0, exp_tab[f]});
    end
    setcfg(8'h12, 8'd1, 8'd32, 8'd3);
    meas(32'h0000_8000, 3);
    cd(32'd2048);
    meas(32'h0000_0010, 2);
    cd(32'd2048);
    meas(32'h0000_0010, 1);
    cd(32'd640);
    rd(`STATUS_OFF, 32'h0001_0280);
    wr(`FILT_OFF, 32'h0, 1'b1);
    wr(`BEAM_OFF, 32'h0000_2000, 1'b1);
    wr(`BEAM_OFF, 32'h0000_2101, 1'b1);
    wr(`STATUS_OFF, 32'h0, 1'b1);
    wr(12'h020, 32'h0, 1'b1);
    rd(`FILT_OFF, 32'h0000_0003);
    for (int r = 0; r < 7; r++) begin
      @(posedge clk);
      pcfg <= {8'h01, 8'h20, 8'h01, 5'b00010, r[2:0]};
      pwe <= 1'b1;
      @(posedge clk);
      pwe <= 1'b0;
      meas(32'h0000_8000, 1);
      chk(nvq, pcfg);
      chk({30'h0, ven, cen}, {30'h0, r > 0 && r < 4, r > 3});
      k = (r == 4) ? 32'd2457 : (r == 0) ? 32'h0 : 32'd2048;
      cd(k);
      chk({20'h0, vv}, (r > 0 && r < 4) ? k : 32'h0);
      chk({20'h0, cv}, (r > 3) ? k : 32'h0);
    end
    nvd <= 32'h0110_0225;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(`ACTIVE_OFF, 32'h0110_0225);
    end_sim();
  end
endmodule
